// File: sgc_top.sv
// Serial control port of a two-channel preamplifier gain controller
`timescale 1ns/1ps
`include "sgc_defs.svh"

module sgc_top #(
	parameter int TIMEOUT_CYC = `SGC_ZC_TIMEOUT_CYC
) (
	input  wire logic       ref_clk_i,
	input  wire logic       srst_i,
	input  wire logic       sclk_i,
	input  wire logic       cs_n_i,
	input  wire logic       din_i,
	output logic            dout_o,
	output logic            dout_oe_o,
	input  wire logic [1:0] zero_cross_detector_i,
	output logic [4:0]      first_channel_gain_code_o,
	output logic [4:0]      second_channel_gain_code_o,
	output logic            first_channel_output_bit_o,
	output logic            second_channel_output_bit_o,
	output logic [1:0]      update_pending_flag_o
);
	import sgc_pkg::*;

	typedef struct packed {
		logic                   cs_s1;
		logic                   cs_s2;
		logic                   cs_s3;
		logic [1:0]             zc_s1;
		logic [1:0]             zc_s2;
		logic [1:0]             zc_s3;
		logic [`SGC_WORD_W-1:0] word;
		logic                   load;
	} sgc_top_st_t;

	sgc_top_st_t            st_q;
	sgc_top_st_t            st_d;
	logic [`SGC_WORD_W-1:0] link_word;
	logic [1:0]             zero_cross_event;
	sgc_chan_t              chan1;
	sgc_chan_t              chan2;
	sgc_cfg_t               cfg1;
	sgc_cfg_t               cfg2;

	sgc_link_shift u_link (
		.sclk_i    (sclk_i),
		.cs_n_i    (cs_n_i),
		.din_i     (din_i),
		.word_o    (link_word),
		.dout_o    (dout_o),
		.dout_oe_o (dout_oe_o)
	);

	// Link word is static while chip select is high, so sampling after the
	// synchronised rising edge is a safe crossing
	always_comb begin
		st_d       = st_q;
		st_d.cs_s1 = cs_n_i;
		st_d.cs_s2 = st_q.cs_s1;
		st_d.cs_s3 = st_q.cs_s2;
		st_d.zc_s1 = zero_cross_detector_i;
		st_d.zc_s2 = st_q.zc_s1;
		st_d.zc_s3 = st_q.zc_s2;
		st_d.load  = st_q.cs_s2 & ~st_q.cs_s3;
		if (st_q.cs_s2 && !st_q.cs_s3) begin
			st_d.word = link_word;
		end
		if (srst_i) begin
			st_d       = '0;
			st_d.cs_s1 = 1'b1;
			st_d.cs_s2 = 1'b1;
			st_d.cs_s3 = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		st_q <= st_d;
	end

	assign zero_cross_event = st_q.zc_s2 & ~st_q.zc_s3;

	// First channel word arrives first, so it sits in the upper half
	assign cfg1 = sgc_decode(st_q.word[`SGC_WORD_W-1:`SGC_CHAN_W]);
	assign cfg2 = sgc_decode(st_q.word[`SGC_CHAN_W-1:0]);

	sgc_chan_update #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chan1 (
		.ref_clk_i (ref_clk_i),
		.srst_i    (srst_i),
		.load_i    (st_q.load),
		.cfg_i     (cfg1),
		.zc_i      (zero_cross_event[0]),
		.chan_o    (chan1)
	);

	sgc_chan_update #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chan2 (
		.ref_clk_i (ref_clk_i),
		.srst_i    (srst_i),
		.load_i    (st_q.load),
		.cfg_i     (cfg2),
		.zc_i      (zero_cross_event[1]),
		.chan_o    (chan2)
	);

	// Sync selects live only in the loaded word and are zero after reset
	assign first_channel_gain_code_o   = chan1.gain;
	assign second_channel_gain_code_o  = chan2.gain;
	assign first_channel_output_bit_o  = chan1.out;
	assign second_channel_output_bit_o = chan2.out;
	assign update_pending_flag_o       = {chan2.busy, chan1.busy};

endmodule

// File: sgc_defs.svh
// Constants for the serial gain control port: word layout, reset values and timing
`ifndef SGC_DEFS_SVH
`define SGC_DEFS_SVH

`define SGC_WORD_W         32
`define SGC_CHAN_W         16
`define SGC_GAIN_LSB       0
`define SGC_GAIN_W         5
`define SGC_OUT_BIT        5
`define SGC_GSYNC_BIT      6
`define SGC_OSYNC_BIT      7
`define SGC_GAIN_MAX       5'h11
`define SGC_GAIN_RST       5'h00
`define SGC_OUT_RST        1'b0
`define SGC_SYNC_RST       1'b0
`define SGC_CLK_PERIOD_NS  10
`define SGC_ZC_TIMEOUT_MS  24
`define SGC_ZC_TIMEOUT_CYC ((`SGC_ZC_TIMEOUT_MS * 1000000) / `SGC_CLK_PERIOD_NS)
`define SGC_TMR_W          22

`endif

// File: sgc_pkg.sv
// Types and decode functions shared by the serial gain control port
`include "sgc_defs.svh"

package sgc_pkg;

	typedef struct packed {
		logic                    osync;
		logic                    gsync;
		logic                    out;
		logic [`SGC_GAIN_W-1:0]  gain;
	} sgc_cfg_t;

	typedef struct packed {
		logic [`SGC_GAIN_W-1:0]  gain;
		logic                    out;
		logic                    busy;
	} sgc_chan_t;

	// Splits one 16-bit channel word into its fields
	function automatic sgc_cfg_t sgc_decode(input logic [`SGC_CHAN_W-1:0] w);
		sgc_cfg_t c;
		c.gain  = w[`SGC_GAIN_LSB +: `SGC_GAIN_W];
		c.out   = w[`SGC_OUT_BIT];
		c.gsync = w[`SGC_GSYNC_BIT];
		c.osync = w[`SGC_OSYNC_BIT];
		return c;
	endfunction

	// Gain codes above the top step are not accepted
	function automatic logic sgc_gain_ok(input logic [`SGC_GAIN_W-1:0] g);
		return g <= `SGC_GAIN_MAX;
	endfunction

endpackage

// File: sgc_link_shift.sv
// Shift register and serial output running on the serial clock
`timescale 1ns/1ps
`include "sgc_defs.svh"

module sgc_link_shift (
	input  wire logic                   sclk_i,
	input  wire logic                   cs_n_i,
	input  wire logic                   din_i,
	output logic      [`SGC_WORD_W-1:0] word_o,
	output logic                        dout_o,
	output logic                        dout_oe_o
);
	import sgc_pkg::*;

	typedef struct packed {
		logic [`SGC_WORD_W-1:0] shift;
	} sgc_link_st_t;

	sgc_link_st_t link_q;
	sgc_link_st_t link_d;
	logic         dout_q;

	// Shift on rising edges only while selected; the last 32 bits stay
	always_comb begin
		link_d = link_q;
		if (!cs_n_i) begin
			link_d.shift = {link_q.shift[`SGC_WORD_W-2:0], din_i};
		end
	end

	always_ff @(posedge sclk_i) begin
		link_q <= link_d;
	end

	// Bit leaving the register moves out on the falling edge
	always_ff @(negedge sclk_i) begin
		if (!cs_n_i) begin
			dout_q <= link_q.shift[`SGC_WORD_W-1];
		end
	end

	assign word_o    = link_q.shift;
	assign dout_o    = dout_q;
	assign dout_oe_o = ~cs_n_i;

endmodule

// File: sgc_chan_update.sv
// One channel: applies gain and output settings now, or at a zero crossing or when the wait times out
`timescale 1ns/1ps
`include "sgc_defs.svh"

module sgc_chan_update #(
	parameter int TIMEOUT_CYC = `SGC_ZC_TIMEOUT_CYC
) (
	input  wire logic              ref_clk_i,
	input  wire logic              srst_i,
	input  wire logic              load_i,
	input  wire sgc_pkg::sgc_cfg_t cfg_i,
	input  wire logic              zc_i,
	output sgc_pkg::sgc_chan_t     chan_o
);
	import sgc_pkg::*;

	localparam logic [`SGC_TMR_W-1:0] TMR_LAST = `SGC_TMR_W'(TIMEOUT_CYC - 1);

	typedef struct packed {
		logic [`SGC_GAIN_W-1:0] gain;
		logic                   out;
		logic [`SGC_GAIN_W-1:0] pgain;
		logic                   pg;
		logic                   pout;
		logic                   po;
		logic [`SGC_TMR_W-1:0]  tmr;
	} sgc_chan_st_t;

	sgc_chan_st_t st_q;
	sgc_chan_st_t st_d;
	logic         expire;

	always_comb begin
		st_d   = st_q;
		expire = (st_q.tmr == TMR_LAST);
		if (st_q.pg || st_q.po) begin
			st_d.tmr = st_q.tmr + `SGC_TMR_W'(1);
		end
		// Pending changes land on a crossing or when the wait runs out
		if (st_q.pg && (zc_i || expire)) begin
			st_d.gain = st_q.pgain;
			st_d.pg   = 1'b0;
		end
		if (st_q.po && (zc_i || expire)) begin
			st_d.out = st_q.pout;
			st_d.po  = 1'b0;
		end
		if (!st_d.pg && !st_d.po) begin
			st_d.tmr = '0;
		end
		if (load_i) begin
			if (sgc_gain_ok(cfg_i.gain)) begin
				if (cfg_i.gsync) begin
					st_d.pgain = cfg_i.gain;
					st_d.pg    = 1'b1;
					st_d.tmr   = '0;
				end else begin
					st_d.gain = cfg_i.gain;
					st_d.pg   = 1'b0;
				end
			end
			if (cfg_i.osync) begin
				st_d.pout = cfg_i.out;
				st_d.po   = 1'b1;
				st_d.tmr  = '0;
			end else begin
				st_d.out = cfg_i.out;
				st_d.po  = 1'b0;
			end
		end
		if (srst_i) begin
			st_d      = '0;
			st_d.gain = `SGC_GAIN_RST;
			st_d.out  = `SGC_OUT_RST;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		st_q <= st_d;
	end

	assign chan_o = '{gain: st_q.gain, out: st_q.out, busy: st_q.pg};

endmodule

// File: sgc_top_assertions.sv
// Checker for the serial gain control port
`timescale 1ns/1ps
module sgc_top_assertions #(
	parameter int TIMEOUT_CYC = 20
) (
	input wire logic       ref_clk_i,
	input wire logic       srst_i,
	input wire logic       sclk_i,
	input wire logic       cs_n_i,
	input wire logic       din_i,
	input wire logic       dout_o,
	input wire logic       dout_oe_o,
	input wire logic [1:0] zero_cross_detector_i,
	input wire logic [4:0] first_channel_gain_code_o,
	input wire logic [4:0] second_channel_gain_code_o,
	input wire logic       first_channel_output_bit_o,
	input wire logic       second_channel_output_bit_o,
	input wire logic [1:0] update_pending_flag_o
);
	localparam int BMAX = TIMEOUT_CYC + 4;
	logic [3:0] hi_q;
	wire  [4:0] g1   = first_channel_gain_code_o;
	wire  [1:0] b    = update_pending_flag_o;
	// Cycles since chip select was last low
	always_ff @(posedge ref_clk_i) begin
		hi_q <= (srst_i || !cs_n_i) ? 4'h0 : hi_q + {3'h0, hi_q != 4'hf};
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);
	property p_oe; dout_oe_o == !cs_n_i; endproperty
	a_oe: assert property (p_oe) else $error("dout enable wrong");
	property p_rng; g1 <= 5'h11 && second_channel_gain_code_o <= 5'h11; endproperty
	a_rng: assert property (p_rng) else $error("gain out of range");
	property p_rst; $fell(srst_i) |-> g1 == 5'h00 && !first_channel_output_bit_o && b == 2'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("reset values wrong");
	property p_when; $changed(g1) |-> hi_q inside {[4'h2:4'h8]} || $past(b[0]); endproperty
	a_when: assert property (p_when) else $error("gain changed off load");
	property p_hold; b[0] && $past(b[0]) |-> $stable(g1); endproperty
	a_hold: assert property (p_hold) else $error("gain moved while busy");
	property p_hold2; b[1] && $past(b[1]) |-> $stable(second_channel_gain_code_o); endproperty
	a_hold2: assert property (p_hold2) else $error("gain two moved while busy");
	property p_bmax; $rose(b[0]) |-> ##[1:BMAX] !b[0]; endproperty
	a_bmax: assert property (p_bmax) else $error("busy too long");
	property p_zc; b[0] && $rose(zero_cross_detector_i[0]) |-> ##[1:5] !b[0]; endproperty
	a_zc: assert property (p_zc) else $error("crossing not applied");
	cover property ($fell(b[0]));
	cover property (b[0] && $rose(zero_cross_detector_i[0]));
	cover property ($changed(g1));
endmodule
bind sgc_top sgc_top_assertions #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_chk (.*);

// File: sgc_host.sv
// Host master model driving the serial control link
`timescale 1ns/1ps
module sgc_host (
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      din_o,
	input  wire logic dout_i
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		din_o  = 1'b0;
	end
	// Idle clock edges, then n bits MSB first; returned bits in r
	task automatic xfer(input logic [63:0] w, input int n, output logic [63:0] r);
		r = 64'h0;
		repeat (4) #15 sclk_o = ~sclk_o;
		#3 cs_n_o = 1'b0;
		#50;
		for (int i = n - 1; i >= 0; i--) begin
			din_o = w[i];
			#15 sclk_o = 1'b1;
			r[i] = dout_i;
			#15 sclk_o = 1'b0;
		end
		#15 cs_n_o = 1'b1;
		din_o = ~din_o;
	endtask
endmodule

// File: tb.sv
// Self-checking bench for the serial gain control port
`timescale 1ns/1ps
module tb;
	import sgc_pkg::*;
	localparam int TMO = 20;
	logic        ref_clk_i = 1'b0;
	logic        srst_i    = 1'b1;
	logic [1:0]  zc        = 2'h0;
	wire         sclk, cs_n, din, dout, oe;
	wire  [4:0]  g [2];
	wire         o [2];
	wire  [1:0]  busy;
	int          mismatches = 0;
	int          tests_run  = 0;
	int          seed       = 43;
	int          cyc        = 0;
	logic [63:0] r;
	logic [31:0] w, prev;
	logic [4:0]  eg [2];
	logic        eo [2];
	// Deselected output line shows the inverse of the last bit
	sgc_host i_host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(oe ? dout : ~dout));
	sgc_top #(.TIMEOUT_CYC(TMO)) i_dut (
		.ref_clk_i(ref_clk_i), .srst_i(srst_i), .sclk_i(sclk), .cs_n_i(cs_n),
		.din_i(din), .dout_o(dout), .dout_oe_o(oe), .zero_cross_detector_i(zc),
		.first_channel_gain_code_o(g[0]), .second_channel_gain_code_o(g[1]),
		.first_channel_output_bit_o(o[0]), .second_channel_output_bit_o(o[1]),
		.update_pending_flag_o(busy));
	initial begin
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [15:0] half(int c);
		return c ? w[15:0] : w[31:16];
	endfunction
	function automatic logic [4:0] nxt(logic [4:0] old, logic [15:0] h);
		return h[4:0] <= 5'h11 ? h[4:0] : old;
	endfunction
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			final_report();
		end
	end
	initial begin
		logic [15:0] h;
		logic        pg;
		logic        lng;
		repeat (5) @(posedge ref_clk_i);
		@(negedge ref_clk_i) srst_i = 1'b0;
		for (int c = 0; c < 2; c++) begin
			chk(g[c], 0);
			chk(o[c], 0);
			chk(busy[c], 0);
			eg[c] = 5'h00;
			eo[c] = 1'b0;
		end
		for (int k = 0; k < 24; k++) begin
			w = $random(seed);
			lng = w[13];
			if (k < 4) begin
				w[20:16] = 5'h10 + k[4:0];
				w[4:0] = 5'h1f - k[4:0];
			end
			if (k == 4 || k == 5) begin
				w[22] = 1'b1;
				w[20] = 1'b0;
			end
			i_host.xfer({$random(seed), w}, lng ? 64 : 32, r);
			if (k > 0) chk(lng ? r[63:32] : r[31:0], prev);
			repeat (8) @(negedge ref_clk_i);
			for (int c = 0; c < 2; c++) begin
				h = half(c);
				pg = h[6] && h[4:0] <= 5'h11;
				chk(busy[c], pg);
				chk(g[c], pg ? eg[c] : nxt(eg[c], h));
				chk(o[c], h[7] ? eo[c] : h[5]);
				eg[c] = nxt(eg[c], h);
				eo[c] = h[5];
			end
			if (w[23] | w[22] | w[7] | w[6]) begin
				if (k[0] == 1'b0) begin
					zc = 2'h3;
					repeat (6) @(negedge ref_clk_i);
				end else begin
					repeat (TMO + 4) @(negedge ref_clk_i);
				end
				for (int c = 0; c < 2; c++) begin
					chk(g[c], eg[c]);
					chk(o[c], eo[c]);
					chk(busy[c], 0);
				end
				zc = 2'h0;
			end
			prev = w;
			repeat (6) @(negedge ref_clk_i);
		end
		final_report();
	end
endmodule
